//--- src/sar_converter_sequencer.sv
// sequencer, register file and result handling of the 10-bit successive-approximation converter
// Functional notes
// - start bit reads high until conversion ends
// - channel change applies after running conversion
// - 10-bit result, right or left aligned
// - low-byte read blocks updates until high read
// - done flag still sets when result dropped
// - prescaler runs while enabled, else held reset
// - start on next edge; differential every other
// - normal 13 cycles, first one 25
// - sample at 1.5 or 13.5 cycles
// - completion stores result, flags, clears start
// - free-run restarts at once, start stays high
// - selection follows buffer until conversion starts
// - copying resumes in final conversion cycle
// - halted processor starts a noise-reduced conversion
// - completion interrupt wakes the sleeping processor
// - single-ended code scales input to reference
// - differential code saturates at zero
// - input select fields and zero reset
// - reference change waits for completion
// - divider codes map to divide by 2..128
// - left-adjust change re-presents result at once
// - disabling aborts; writing zero to start ignored
// - flag cleared by vector or writing one
//
// Decided for this implementation: strobed register access.
`include "sar_converter_sequencer_regs.svh"
`default_nettype none
module sar_converter_sequencer (
  input wire logic clk,
  input wire logic nrst,
  input wire sar_seq_pkg::bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic cmp_decision,
  output logic [9:0] trial_code,
  output logic sample_hold,
  output sar_seq_pkg::sel_t active_sel,
  output logic converting,
  input wire logic cpu_halted,
  input wire logic global_irq_en,
  input wire logic irq_ack,
  output logic done_irq
);
  import sar_seq_pkg::*;

  state_t s_r; // registered state
  state_t s_nxt; // next state
  logic rise; // converter clock rising instant
  logic fall; // converter clock falling instant, for the half-cycle sample point
  logic go; // a conversion begins this cycle
  logic last; // final converter cycle of the running conversion
  logic done_evt; // conversion completes this cycle
  logic diff_sel; // active channel is a differential pair
  logic [7:0] div; // system clock division factor
  logic [4:0] len; // length of the running conversion
  logic [4:0] sh_cyc; // whole cycles before the sample point
  logic rd_low; // low result byte is being read
  logic rd_high; // high result byte is being read

  // timing at a glance, counted in converter cycles from the start:
  // - the prescaler counts system clocks; its last count marks a rising instant
  // - its middle count marks the falling instant, used only for the sample point
  // - cycles run from 0; a normal conversion samples at the falling instant of cycle 1
  // - an extended conversion samples in cycle 13 and runs to cycle 24
  // - one trial bit per cycle follows the sample, most significant first
  // - the comparator answer is taken at the rising instant that ends the cycle
  // - completion falls on the rising instant that ends the last cycle
  // - the active selection reopens in that last cycle, so the next start sees it
  // - a start write is honoured only together with the enable bit
  // - software clears the flag by writing one; a read-modify-write may drop it
  // - the result pair stays frozen from a low-byte read to a high-byte read
  // - the extended-first marker is rearmed whenever the enable bit drops
  // - no long counts are kept, so the slowest divider costs only seven bits
  // next-state logic: bus access first, then the sequencer, so hardware sets win
  always_comb begin
    logic start_wr;
    logic [4:0] k;
    logic [4:0] nsh;
    logic [4:0] idx;
    start_wr = 1'b0;
    k = 5'h00;
    nsh = 5'h00;
    idx = 5'h00;
    s_nxt = s_r;
    s_nxt.sh = 1'b0;
    s_nxt.rdata = 8'h00;
    s_nxt.halt_q = cpu_halted;
    // divide by 2 for the two lowest codes, else a power of two
    div = (s_r.ps < 3'h2) ? 8'h02 : (8'h01 << s_r.ps);
    rise = s_r.en && ({1'b0, s_r.pre} == 8'(div - 8'h01));
    fall = s_r.en && ({1'b0, s_r.pre} == 8'((div >> 1) - 8'h01));
    diff_sel = (s_r.act.chan >= `DIFF_CODE_LO) && (s_r.act.chan <= `DIFF_CODE_HI);
    len = s_r.ext ? `EXTENDED_LEN : `NORMAL_LEN;
    sh_cyc = s_r.ext ? `EXTENDED_SH_CYC : `NORMAL_SH_CYC;
    last = s_r.busy && (s_r.cyc == 5'(len - 5'h01));
    done_evt = rise && last;
    rd_low = bus_req.rd && (bus_req.addr == `RESULT_LOW_OFS);
    rd_high = bus_req.rd && (bus_req.addr == `RESULT_HIGH_OFS);
    // register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `CONTROL_STATUS_OFS: begin
          s_nxt.en = bus_req.wdata[`CCS_EN_BIT];
          s_nxt.free_run = bus_req.wdata[`CCS_FREE_RUN_BIT];
          s_nxt.irq_en = bus_req.wdata[`CCS_IRQ_EN_BIT];
          s_nxt.ps = bus_req.wdata[2:0];
          // writing zero to start has no effect; a one needs the enable set
          start_wr = bus_req.wdata[`CCS_START_BIT] && bus_req.wdata[`CCS_EN_BIT];
          // flag clears on a written one; read-modify-write can lose it
          if (bus_req.wdata[`CCS_DONE_FLAG_BIT]) begin
            s_nxt.flag = 1'b0;
          end
        end
        `INPUT_SELECT_OFS: begin
          s_nxt.isel = bus_req.wdata; // buffer only, written freely
        end
        default: begin
          // result bytes are read-only, other offsets ignore writes
        end
      endcase
    end
    if (irq_ack) begin
      s_nxt.flag = 1'b0; // cleared as the vector executes
    end
    // register reads, data in the following cycle
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `CONTROL_STATUS_OFS: s_nxt.rdata = {s_r.en, s_r.start, s_r.free_run, s_r.flag, s_r.irq_en, s_r.ps};
        `INPUT_SELECT_OFS: s_nxt.rdata = s_r.isel;
        // alignment follows the live left-adjust bit, so a change shows at once
        `RESULT_HIGH_OFS: begin
          s_nxt.rdata = s_r.isel[`ISEL_LADJ_BIT] ? s_r.res[9:2] : {6'h00, s_r.res[9:8]};
        end
        `RESULT_LOW_OFS: begin
          s_nxt.rdata = s_r.isel[`ISEL_LADJ_BIT] ? {s_r.res[1:0], 6'h00} : s_r.res[7:0];
        end
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    // result pair lock: low read closes it, high read opens it
    if (rd_low) begin
      s_nxt.lock = 1'b1;
    end else if (rd_high) begin
      s_nxt.lock = 1'b0;
    end
    // noise-reduced conversion: start once the processor halts in a quiet setup
    if (cpu_halted && !s_r.halt_q && s_r.en && !s_r.start && !s_r.free_run && s_r.irq_en) begin
      start_wr = 1'b1;
    end
    // prescaler is held in reset while disabled
    if (!s_r.en) begin
      s_nxt.pre = 7'h00;
      s_nxt.par = 1'b0;
    end else if (rise) begin
      s_nxt.pre = 7'h00;
      s_nxt.par = ~s_r.par;
    end else begin
      s_nxt.pre = s_r.pre + 7'h01;
    end
    // differential pairs may start only on every other edge since enable
    go = rise && s_r.start && !s_r.busy && (!diff_sel || !s_r.par);
    // active selection tracks the buffer when idle and in the last cycle
    if (!s_r.busy || last) begin
      s_nxt.act.ref_sel = s_r.isel[7:6];
      s_nxt.act.chan = s_r.isel[4:0];
    end
    // sample point half a converter cycle after the whole-cycle count
    if (fall && s_r.busy && (s_r.cyc == sh_cyc)) begin
      s_nxt.sh = 1'b1;
    end
    if (go) begin
      s_nxt.busy = 1'b1;
      s_nxt.cyc = 5'h00;
      s_nxt.ext = s_r.first; // first conversion after enable is extended
      s_nxt.first = 1'b0;
      s_nxt.sar = 10'h000;
    end else if (rise && s_r.busy) begin
      if (last) begin
        // a blocked pair drops the result, the flag is still raised
        if (!(s_r.lock || rd_low)) begin
          s_nxt.res = s_r.sar;
        end
        s_nxt.flag = 1'b1;
        if (s_r.free_run) begin
          s_nxt.cyc = 5'h00;
          s_nxt.ext = 1'b0;
          s_nxt.sar = 10'h000;
        end else begin
          s_nxt.busy = 1'b0;
          s_nxt.start = 1'b0;
        end
      end else begin
        s_nxt.cyc = s_r.cyc + 5'h01;
        // comparator decision for the trial bit shown during this cycle
        if ((s_r.cyc > sh_cyc) && (s_r.cyc <= 5'(sh_cyc + `RESULT_BITS))) begin
          k = 5'(s_r.cyc - sh_cyc - 5'h01);
          idx = 5'(5'h09 - k);
          s_nxt.sar[idx[3:0]] = cmp_decision;
        end
      end
    end
    // a start written now survives a completion clearing start in the same cycle
    if (start_wr) begin
      s_nxt.start = 1'b1;
    end
    // disabling aborts and rearms the extended first conversion
    if (!s_nxt.en) begin
      s_nxt.busy = 1'b0;
      s_nxt.start = 1'b0;
      s_nxt.cyc = 5'h00;
      s_nxt.first = 1'b1;
    end
    // trial word for the analog core: decided bits plus the bit under test
    nsh = s_nxt.ext ? `EXTENDED_SH_CYC : `NORMAL_SH_CYC;
    s_nxt.trial = 10'h000;
    if (s_nxt.busy && (s_nxt.cyc > nsh) && (s_nxt.cyc <= 5'(nsh + `RESULT_BITS))) begin
      k = 5'(s_nxt.cyc - nsh - 5'h01);
      idx = 5'(5'h09 - k);
      s_nxt.trial = s_nxt.sar | (10'h001 << idx[3:0]);
    end
    // single level request to the processor
    s_nxt.irq = s_nxt.flag && s_nxt.irq_en && global_irq_en;
  end

  // state register; first conversion after reset is extended
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.first <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign rdata = s_r.rdata;
  assign trial_code = s_r.trial;
  assign sample_hold = s_r.sh;
  assign active_sel = s_r.act;
  assign converting = s_r.busy;
  assign done_irq = s_r.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_start_while_busy: assert property (s_r.busy |-> s_r.start)
    else $error("start bit low during a conversion");
  chk_single_clears_start: assert property (done_evt && !s_r.free_run && !bus_req.wr && !cpu_halted |=> !s_r.start && !s_r.busy)
    else $error("single conversion did not clear start");
  chk_free_run_restart: assert property (done_evt && s_r.free_run && s_nxt.en |=> s_r.busy && s_r.start && s_r.cyc == 5'h00)
    else $error("free running conversion did not restart");
  chk_locked_select: assert property (s_r.busy && !last && !go |=> $stable(s_r.act))
    else $error("active selection moved during conversion");
  chk_blocked_result: assert property (done_evt && s_r.lock |=> $stable(s_r.res) && s_r.flag)
    else $error("blocked result pair changed or flag missing");
  chk_flag_sets: assert property (done_evt |=> s_r.flag)
    else $error("completion did not set the flag");
  chk_prescaler_reset: assert property (!s_r.en |=> s_r.pre == 7'h00)
    else $error("prescaler counted while disabled");
  chk_conv_length: assert property (done_evt |-> s_r.cyc == (s_r.ext ? 5'h18 : 5'h0C))
    else $error("conversion length wrong");
  chk_sample_point: assert property (s_nxt.sh |-> fall && s_r.cyc == (s_r.ext ? 5'h0D : 5'h01))
    else $error("sample instant wrong");
  chk_diff_gate: assert property (go && diff_sel |-> !s_r.par)
    else $error("differential start on odd edge");
  chk_irq_level: assert property (s_nxt.flag && s_nxt.irq_en && global_irq_en |=> s_r.irq)
    else $error("interrupt request missing");

  // start bit is visible to software
  chk_start_readback: assert property (bus_req.rd && bus_req.addr == `CONTROL_STATUS_OFS
    |=> rdata[`CCS_START_BIT] == $past(s_r.start))
    else $error("start bit read back wrong");

  // the selection buffer reads back as written
  chk_isel_readback: assert property (bus_req.rd && bus_req.addr == `INPUT_SELECT_OFS
    |=> rdata == $past(s_r.isel))
    else $error("input select read back wrong");

  // the buffer takes every write at once
  chk_isel_write: assert property (bus_req.wr && bus_req.addr == `INPUT_SELECT_OFS
    |=> s_r.isel == $past(bus_req.wdata))
    else $error("input select write lost");

  // a zero written to start leaves a pending or running start alone
  chk_zero_start_ignored: assert property (bus_req.wr && bus_req.addr == `CONTROL_STATUS_OFS
    && !bus_req.wdata[`CCS_START_BIT] && bus_req.wdata[`CCS_EN_BIT] && s_r.start && !done_evt |=> s_r.start)
    else $error("zero write cleared start");

  // dropping the enable ends any conversion at once
  chk_disable_aborts: assert property (bus_req.wr && bus_req.addr == `CONTROL_STATUS_OFS
    && !bus_req.wdata[`CCS_EN_BIT] |=> !s_r.busy && !s_r.start)
    else $error("disable did not abort");

  // left aligned high byte carries the top eight bits
  chk_left_high: assert property (rd_high && s_r.isel[`ISEL_LADJ_BIT]
    |=> rdata == $past(s_r.res[9:2]))
    else $error("left aligned high byte wrong");

  // right aligned low byte carries the bottom eight bits
  chk_right_low: assert property (rd_low && !s_r.isel[`ISEL_LADJ_BIT]
    |=> rdata == $past(s_r.res[7:0]))
    else $error("right aligned low byte wrong");

  // a low-byte read closes the pair
  chk_low_read_locks: assert property (rd_low
    |=> s_r.lock)
    else $error("low read did not lock");

  // a high-byte read opens the pair again
  chk_high_read_unlocks: assert property (rd_high
    |=> !s_r.lock)
    else $error("high read did not unlock");

  // an open pair takes the finished word
  chk_result_update: assert property (done_evt && !s_r.lock && !rd_low
    |=> s_r.res == $past(s_r.sar))
    else $error("result not stored");

  // the result moves only at a completion
  chk_result_hold: assert property (!done_evt
    |=> $stable(s_r.res))
    else $error("result changed without completion");

  // while idle the active selection copies the buffer
  chk_select_follows: assert property (!s_r.busy
    |=> s_r.act == $past({s_r.isel[7:6], s_r.isel[4:0]}))
    else $error("idle selection not copied");

  // a start at a rising instant opens cycle zero
  chk_go_begins: assert property (go && s_nxt.en
    |=> s_r.busy && s_r.cyc == 5'h00)
    else $error("conversion did not begin");

  // a pending start waits for the rising instant
  chk_no_early_start: assert property (s_r.start && !s_r.busy && !rise
    |=> !s_r.busy)
    else $error("conversion began off a rising instant");

  // the first conversion after enable is extended
  chk_extended_first: assert property (go && s_r.first
    |=> s_r.ext)
    else $error("first conversion not extended");

  // later conversions are normal length
  chk_normal_after: assert property (go && !s_r.first
    |=> !s_r.ext)
    else $error("later conversion extended");

  // the sample strobe is a single system cycle
  chk_sample_pulse: assert property (s_r.sh
    |=> !s_r.sh)
    else $error("sample strobe too long");

  // no trial word reaches the analog core while idle
  chk_trial_idle: assert property (!s_r.busy
    |-> s_r.trial == 10'h000)
    else $error("trial word while idle");

  // a written one clears the flag unless a completion sets it
  chk_flag_write_clear: assert property (bus_req.wr && bus_req.addr == `CONTROL_STATUS_OFS
    && bus_req.wdata[`CCS_DONE_FLAG_BIT] && !done_evt |=> !s_r.flag)
    else $error("flag write did not clear");

  // the vector acknowledge clears the flag
  chk_ack_clear: assert property (irq_ack && !done_evt
    |=> !s_r.flag)
    else $error("acknowledge did not clear flag");

  // a halt in the quiet setup raises start
  chk_sleep_start: assert property (cpu_halted && !s_r.halt_q && s_r.en && !s_r.start && !s_r.free_run
    && s_r.irq_en && !bus_req.wr |=> s_r.start)
    else $error("halt did not start a conversion");

  // the global mask silences the request
  chk_global_mask: assert property (!global_irq_en
    |=> !s_r.irq)
    else $error("request despite global mask");
endmodule
`default_nettype wire

//--- src/sar_converter_sequencer_regs.svh
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SAR_CONVERTER_SEQUENCER_REGS_SVH
`define SAR_CONVERTER_SEQUENCER_REGS_SVH
// register offsets on the byte-wide i/o port
`define RESULT_LOW_OFS 8'h04
`define RESULT_HIGH_OFS 8'h05
`define CONTROL_STATUS_OFS 8'h06
`define INPUT_SELECT_OFS 8'h07
// converter_control_status field positions
`define CCS_EN_BIT 7
`define CCS_START_BIT 6
`define CCS_FREE_RUN_BIT 5
`define CCS_DONE_FLAG_BIT 4
`define CCS_IRQ_EN_BIT 3
// input_select_register field positions
`define ISEL_LADJ_BIT 5
// reset values
`define CCS_RESET 8'h00
`define ISEL_RESET 8'h00
// conversion timing in converter clock cycles
`define NORMAL_LEN 5'h0D
`define EXTENDED_LEN 5'h19
`define NORMAL_SH_CYC 5'h01
`define EXTENDED_SH_CYC 5'h0D
`define RESULT_BITS 5'h0A
// differential channel code range
`define DIFF_CODE_LO 5'h0B
`define DIFF_CODE_HI 5'h1D
`endif

//--- src/sar_seq_pkg.sv
// shared types of the converter sequencer: bus request, selection and state
`default_nettype none
package sar_seq_pkg;
  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  // reference and channel selection as applied to the analog front end
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [4:0] chan;
  } sel_t;
  // whole state of the sequencer
  typedef struct packed {
    logic en;
    logic start;
    logic free_run;
    logic flag;
    logic irq_en;
    logic [2:0] ps;
    logic [7:0] isel;
    sel_t act;
    logic [6:0] pre;
    logic par;
    logic first;
    logic busy;
    logic ext;
    logic [4:0] cyc;
    logic [9:0] sar;
    logic [9:0] res;
    logic lock;
    logic halt_q;
    logic [7:0] rdata;
    logic [9:0] trial;
    logic sh;
    logic irq;
  } state_t;
endpackage
`default_nettype wire

//--- tb/sar_analog_model.sv
// behavioural comparator and sample-and-hold standing behind the sequencer's trial port
`default_nettype none
module sar_analog_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] trial_code,
  input wire logic sample_hold,
  input wire logic signed [11:0] level,
  output logic cmp_decision
);
  timeunit 1ns;
  timeprecision 1ps;
  // held input in code units, frozen at the sample instant only
  logic [9:0] held_r;
  // negative difference clips to zero, overrange clips to full scale
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held_r <= 10'h000;
    end else if (sample_hold) begin
      held_r <= (level < 0) ? 10'h000 : (level > 12'sh3FF) ? 10'h3FF : level[9:0];
    end
  end
  // keep the trial bit while the trial word does not exceed the held input
  assign cmp_decision = (trial_code <= held_r);
endmodule
`default_nettype wire

//--- tb/tb_sar_converter_sequencer.sv
// self-checking bench of the converter sequencer: registers, timing, result lock, modes
`include "sar_converter_sequencer_regs.svh"
`default_nettype none
module tb_sar_converter_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_seq_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bus_req_t req = '0;
  logic [7:0] rdata;
  logic cmp_decision, sample_hold, converting, done_irq;
  logic [9:0] trial_code;
  sel_t active_sel;
  logic cpu_halted = 1'b0;
  logic global_irq_en = 1'b0;
  logic irq_ack = 1'b0;
  logic signed [11:0] level = '0; // analog input in code units
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rise_c = 0;
  int sh_c = 0;
  int len_c = 0;
  logic was = 1'b0;
  logic [7:0] r, s;
  logic [9:0] code, old;
  always #4 clk = ~clk;
  sar_converter_sequencer sar_converter_sequencer_inst (.clk(clk), .nrst(nrst), .bus_req(req), .rdata(rdata),
    .cmp_decision(cmp_decision), .trial_code(trial_code), .sample_hold(sample_hold), .active_sel(active_sel),
    .converting(converting), .cpu_halted(cpu_halted), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
    .done_irq(done_irq));
  sar_analog_model sar_analog_model_inst (.clk(clk), .nrst(nrst), .trial_code(trial_code),
    .sample_hold(sample_hold), .level(level), .cmp_decision(cmp_decision));
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // timeout and conversion timing monitor; samples pre-edge values so no race with the design
  always @(posedge clk) begin
    cycles++;
    if (converting === 1'b1 && !was) rise_c = cycles;
    if (sample_hold === 1'b1) sh_c = cycles - rise_c;
    if (converting !== 1'b1 && was) len_c = cycles - rise_c;
    was = (converting === 1'b1);
    if (cycles > 60000) begin
      fails++;
      conclude();
    end
  end
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic int dv(input int p);
    return (p == 0) ? 2 : (1 << p);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // read data is taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // low byte first, then high, as the result pairing demands
  task automatic chk_res(input logic [9:0] c, input logic ladj);
    logic [7:0] lo, hi;
    rd(`RESULT_LOW_OFS, lo);
    rd(`RESULT_HIGH_OFS, hi);
    check({2'b00, lo}, ladj ? {2'b00, c[1:0], 6'h00} : {2'b00, c[7:0]}, "low byte");
    check({2'b00, hi}, ladj ? {2'b00, c[9:2]} : {8'h00, c[9:8]}, "high byte");
  endtask
  // waits for a conversion to run and end; len 0 skips the timing checks
  task automatic wait_done(input int len, input int shh, input int d);
    int n;
    n = 0;
    while (converting !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    while (converting === 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    tick(1);
    if (len > 0) begin
      check(10'(len_c >= len * d - 1 && len_c <= len * d + 1), 10'h001, "length");
      check(10'(sh_c >= shh * d / 2 - 1 && sh_c <= shh * d / 2 + 1), 10'h001, "sample");
    end
  endtask
  initial begin
    void'($urandom(55131));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    global_irq_en <= 1'b1;
    rd(`INPUT_SELECT_OFS, r);
    check({2'b00, r}, 10'h000, "select reset");
    rd(`CONTROL_STATUS_OFS, r);
    check({2'b00, r}, 10'h000, "control reset");
    rd(8'h3C, r);
    check({2'b00, r}, 10'h000, "unmapped read");
    s = {2'($urandom), 1'b0, 5'($urandom % 11)};
    wr(`INPUT_SELECT_OFS, s);
    tick(3);
    check({3'b000, active_sel}, {3'b000, s[7:6], s[4:0]}, "select follows");
    // first conversion after enable is the extended one
    code = 10'($urandom);
    level <= {2'b00, code};
    wr(`CONTROL_STATUS_OFS, 8'hC8);
    wait_done(25, 27, 2);
    rd(`CONTROL_STATUS_OFS, r);
    check({2'b00, r}, 10'h098, "flag set start clear");
    check({9'h000, done_irq}, 10'h001, "irq level");
    chk_res(code, 1'b0);
    // low read locks; a completion meanwhile is dropped but still flags
    old = code;
    rd(`RESULT_LOW_OFS, r);
    level <= {2'b00, ~code};
    wr(`CONTROL_STATUS_OFS, 8'hD8);
    wait_done(13, 3, 2);
    rd(`RESULT_HIGH_OFS, r);
    check({2'b00, r}, {8'h00, old[9:8]}, "locked high");
    check({9'h000, done_irq}, 10'h001, "flag on drop");
    chk_res(old, 1'b0);
    // selection change during a conversion waits for its completion
    wr(`CONTROL_STATUS_OFS, 8'hD8);
    tick(4);
    wr(`INPUT_SELECT_OFS, {~s[7:6], 1'b0, 5'(10 - s[4:0])});
    tick(2);
    check({9'h000, converting}, 10'h001, "still running");
    check({3'b000, active_sel}, {3'b000, s[7:6], s[4:0]}, "select locked");
    wait_done(13, 3, 2);
    check({3'b000, active_sel}, {3'b000, ~s[7:6], 5'(10 - s[4:0])}, "select resumes");
    // every divider code, with full-scale and zero corners
    // the model has no reference error, so the first result after the reference change is kept
    for (int p = 0; p < 8; p++) begin
      code = (p == 7) ? 10'h3FF : (p == 1) ? 10'h000 : 10'($urandom);
      level <= {2'b00, code};
      wr(`CONTROL_STATUS_OFS, 8'hD8 | 8'(p));
      wait_done(13, 3, dv(p));
      chk_res(code, 1'b0);
    end
    wr(`INPUT_SELECT_OFS, 8'h20);
    chk_res(code, 1'b1);
    // free running restarts at once and keeps start high
    wr(`CONTROL_STATUS_OFS, 8'hF8);
    tick(1);
    for (int n = 0; n < 400 && done_irq !== 1'b1; n++) tick(1);
    tick(3);
    check({9'h000, converting}, 10'h001, "free run restart");
    rd(`CONTROL_STATUS_OFS, r);
    check({9'h000, r[`CCS_START_BIT]}, 10'h001, "free run start");
    wr(`CONTROL_STATUS_OFS, 8'h98);
    wait_done(0, 0, 0);
    // disabling aborts; re-enabling gives an extended conversion again
    wr(`CONTROL_STATUS_OFS, 8'hD8);
    tick(6);
    wr(`CONTROL_STATUS_OFS, 8'h08);
    tick(2);
    check({9'h000, converting}, 10'h000, "abort");
    rd(`CONTROL_STATUS_OFS, r);
    check({9'h000, r[`CCS_START_BIT]}, 10'h000, "abort start");
    wr(`INPUT_SELECT_OFS, 8'h0B); // a clipped input reads zero whether settled or not
    level <= -12'sd5;
    wr(`CONTROL_STATUS_OFS, 8'hD8);
    wait_done(25, 27, 2);
    chk_res(10'h000, 1'b0);
    // halted processor starts a conversion whose interrupt wakes it
    wr(`INPUT_SELECT_OFS, 8'h01);
    level <= 12'sh155;
    wr(`CONTROL_STATUS_OFS, 8'h98);
    tick(2);
    check({9'h000, done_irq}, 10'h000, "flag write clear");
    @(posedge clk);
    cpu_halted <= 1'b1;
    wait_done(13, 3, 2);
    check({9'h000, done_irq}, 10'h001, "wake irq");
    global_irq_en <= 1'b0;
    tick(2);
    check({9'h000, done_irq}, 10'h000, "global mask");
    global_irq_en <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    cpu_halted <= 1'b0;
    tick(2);
    check({9'h000, done_irq}, 10'h000, "vector clear");
    chk_res(10'h155, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
